// >>> ssps_pkg.sv
// constants and register map of the synchronous serial port
package ssps_pkg;
  localparam logic [2:0] ADDR_TXSC = 3'h0;
  localparam logic [2:0] ADDR_RXSC = 3'h1;
  localparam logic [2:0] ADDR_BAUDC = 3'h2;
  localparam logic [2:0] ADDR_BRGL = 3'h3;
  localparam logic [2:0] ADDR_HIGH_SPEED_BAUD = 3'h4;
  localparam logic [2:0] ADDR_TXD = 3'h5;
  localparam logic [2:0] ADDR_RXD = 3'h6;
  localparam logic [2:0] ADDR_IRQC = 3'h7;
  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE_MASTER = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HSPD = 2;
  localparam int TX_IDLE = 1;
  localparam int TX_BIT9 = 0;
  // receive_status_control fields
  localparam int RX_PORT_ENABLE = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RX_FRAMING_ERROR_FLAG = 2;
  localparam int RX_OVERRUN_FLAG = 1;
  localparam int RX_BIT9 = 0;
  // baud_control fields
  localparam int BC_RIDLE = 6;
  localparam int BC_WIDE = 3;
  // irq control fields
  localparam int IC_RECEIVE_IRQ_ENABLE = 0;
  localparam int IC_TRANSMIT_IRQ_ENABLE = 1;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 2;
  localparam int IC_GIE = 3;
  localparam int IC_RECEIVE_COMPLETE_FLAG = 4;
  localparam int IC_TRANSMIT_BUFFER_EMPTY_FLAG = 5;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage : ssps_pkg

// >>> ssps_top.sv
// synchronous serial port, master and slave, with register port
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module ssps_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  output logic rx_irq_req,
  output logic wake_req,
  output logic vector_req
);
  typedef struct packed {
    logic clock_source_master, tx9, transmit_enable, sync, high_speed_baud, tx_ninth_bit;
    logic port_enable, rx9, single_receive_enable, continuous_receive_enable, wide;
    logic [15:0] brg;
    logic receive_irq_enable, transmit_irq_enable, peripheral_irq_enable, global_irq_enable;
    logic [8:0] hold;
    logic hold_full;
    logic [8:0] transmit_shift_register;
    logic tx_busy;
    logic [3:0] tx_cnt;
    logic [8:0] receive_shift_register;
    logic [3:0] rx_cnt;
    logic [1:0][8:0] fifo;
    logic [1:0] fcnt;
    logic fhead;
    logic overrun_flag;
    logic ck_lvl;
    logic [15:0] bcnt;
    logic ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
    logic dt_out, ck_oe, dt_oe;
    logic [7:0] rdata;
    logic rxirq, wake, vect;
  } ssps_state_s;

  ssps_state_s s_reg;
  ssps_state_s s_next;
  logic master, slave, rxm, txm, lead, trail, tx_done, rx_done, pop, push, receive_complete_flag, transmit_buffer_empty_flag, wr_rxsc;
  logic [8:0] rx_v;
  logic [15:0] div;

  function automatic logic hit(input logic stb, input logic [2:0] a, input logic [2:0] idx);
    hit = stb && (a == idx);
  endfunction : hit

  assign rdata = s_reg.rdata;
  assign clock_pin_out = s_reg.ck_lvl;
  assign clock_pin_oe = s_reg.ck_oe;
  assign data_pin_out = s_reg.dt_out;
  assign data_pin_oe = s_reg.dt_oe;
  assign rx_irq_req = s_reg.rxirq;
  assign wake_req = s_reg.wake;
  assign vector_req = s_reg.vect;

  always_comb begin
    s_next = s_reg;
    s_next.ck_s1 = clock_pin_in;
    s_next.ck_s2 = s_reg.ck_s1;
    s_next.ck_s3 = s_reg.ck_s2;
    s_next.dt_s1 = data_pin_in;
    s_next.dt_s2 = s_reg.dt_s1;
    lead = 1'h0;
    trail = 1'h0;
    tx_done = 1'h0;
    rx_done = 1'h0;
    push = 1'h0;
    master = s_reg.sync && s_reg.clock_source_master && s_reg.port_enable;
    slave = s_reg.sync && !s_reg.clock_source_master && s_reg.port_enable;
    rxm = s_reg.sync && s_reg.port_enable && (s_reg.single_receive_enable || s_reg.continuous_receive_enable);
    txm = s_reg.sync && s_reg.port_enable && !(s_reg.single_receive_enable || s_reg.continuous_receive_enable) && s_reg.transmit_enable;
    div = s_reg.wide ? s_reg.brg : {8'h00, s_reg.brg[7:0]};
    rx_v = {s_reg.dt_s2, s_reg.receive_shift_register[8:1]};
    pop = hit(rd_stb, addr, ssps_pkg::ADDR_RXD) && (s_reg.fcnt != 2'h0);
    wr_rxsc = hit(wr_stb, addr, ssps_pkg::ADDR_RXSC);
    // clock: own divider in master mode, pin edges in slave mode
    if (master) begin
      if (!(rxm ? !s_reg.overrun_flag : s_reg.tx_busy)) begin
        s_next.bcnt = 16'h0000;
        s_next.ck_lvl = 1'h0;
      end else if (s_reg.bcnt == div) begin
        s_next.bcnt = 16'h0000;
        s_next.ck_lvl = !s_reg.ck_lvl;
        lead = !s_reg.ck_lvl;
        trail = s_reg.ck_lvl;
      end else begin
        s_next.bcnt = s_reg.bcnt + 16'h0001;
      end
    end else begin
      s_next.bcnt = 16'h0000;
      s_next.ck_lvl = 1'h0;
      lead = slave && s_reg.ck_s2 && !s_reg.ck_s3;
      trail = slave && !s_reg.ck_s2 && s_reg.ck_s3;
    end
    if (txm) begin
      if (s_reg.tx_busy) begin
        if (lead) begin
          s_next.dt_out = s_reg.transmit_shift_register[0];
          s_next.transmit_shift_register = {1'h0, s_reg.transmit_shift_register[8:1]};
        end
        if (trail) begin
          if (s_reg.tx_cnt == (s_reg.tx9 ? ssps_pkg::LAST_BIT9 : ssps_pkg::LAST_BIT8)) begin
            tx_done = 1'h1;
            s_next.tx_busy = 1'h0;
            s_next.tx_cnt = 4'h0;
          end else begin
            s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
          end
        end
      end
      if ((!s_reg.tx_busy || tx_done) && s_reg.hold_full) begin
        s_next.transmit_shift_register = s_reg.hold;
        s_next.tx_busy = 1'h1;
        s_next.hold_full = 1'h0;
        s_next.tx_cnt = 4'h0;
      end
    end else begin
      s_next.tx_busy = 1'h0;
      s_next.tx_cnt = 4'h0;
    end
    // receive on trailing edge, slave always continuous
    if (rxm && !s_reg.overrun_flag) begin
      if (trail) begin
        s_next.receive_shift_register = rx_v;
        if (s_reg.rx_cnt == (s_reg.rx9 ? ssps_pkg::LAST_BIT9 : ssps_pkg::LAST_BIT8)) begin
          rx_done = 1'h1;
          s_next.rx_cnt = 4'h0;
        end else begin
          s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
        end
      end
    end else begin
      s_next.rx_cnt = 4'h0;
    end
    if (pop) begin
      s_next.fhead = !s_reg.fhead;
    end
    if (rx_done) begin
      if (s_reg.fcnt != ssps_pkg::FIFO_DEPTH || pop) begin
        push = 1'h1;
        s_next.fifo[s_reg.fhead ^ s_reg.fcnt[0]] = s_reg.rx9 ? rx_v : {1'h0, rx_v[8:1]};
      end
    end
    s_next.fcnt = s_reg.fcnt + {1'h0, push} - {1'h0, pop};
    // in master mode, single receive ends after one character
    if (master && rx_done) begin
      s_next.single_receive_enable = 1'h0;
    end
    // register writes
    if (hit(wr_stb, addr, ssps_pkg::ADDR_TXSC)) begin
      s_next.clock_source_master = wdata[ssps_pkg::TX_CLOCK_SOURCE_MASTER];
      s_next.tx9 = wdata[ssps_pkg::TX_NINE];
      s_next.transmit_enable = wdata[ssps_pkg::TX_EN];
      s_next.sync = wdata[ssps_pkg::TX_SYNC];
      s_next.high_speed_baud = wdata[ssps_pkg::TX_HSPD];
      s_next.tx_ninth_bit = wdata[ssps_pkg::TX_BIT9];
    end
    if (wr_rxsc) begin
      s_next.port_enable = wdata[ssps_pkg::RX_PORT_ENABLE];
      s_next.rx9 = wdata[ssps_pkg::RX_NINE];
      s_next.single_receive_enable = wdata[ssps_pkg::RX_SINGLE_RECEIVE_ENABLE];
      s_next.continuous_receive_enable = wdata[ssps_pkg::RX_CONTINUOUS_RECEIVE_ENABLE];
    end
    if (hit(wr_stb, addr, ssps_pkg::ADDR_BAUDC)) begin
      s_next.wide = wdata[ssps_pkg::BC_WIDE];
    end
    if (hit(wr_stb, addr, ssps_pkg::ADDR_BRGL)) begin
      s_next.brg[7:0] = wdata;
    end
    if (hit(wr_stb, addr, ssps_pkg::ADDR_HIGH_SPEED_BAUD)) begin
      s_next.brg[15:8] = wdata;
    end
    if (hit(wr_stb, addr, ssps_pkg::ADDR_IRQC)) begin
      s_next.receive_irq_enable = wdata[ssps_pkg::IC_RECEIVE_IRQ_ENABLE];
      s_next.transmit_irq_enable = wdata[ssps_pkg::IC_TRANSMIT_IRQ_ENABLE];
      s_next.peripheral_irq_enable = wdata[ssps_pkg::IC_PERIPHERAL_IRQ_ENABLE];
      s_next.global_irq_enable = wdata[ssps_pkg::IC_GIE];
    end
    if (hit(wr_stb, addr, ssps_pkg::ADDR_TXD)) begin
      s_next.hold = {s_reg.tx_ninth_bit, wdata};
      s_next.hold_full = 1'h1;
    end
    // overrun clears on continuous-enable clear or single-mode read; a new overrun wins
    if ((wr_rxsc && !wdata[ssps_pkg::RX_CONTINUOUS_RECEIVE_ENABLE])
        || (hit(rd_stb, addr, ssps_pkg::ADDR_RXD) && s_reg.single_receive_enable && !s_reg.continuous_receive_enable)) begin
      s_next.overrun_flag = 1'h0;
    end
    if (rx_done && !push) begin
      s_next.overrun_flag = 1'h1;
    end
    // disabled port is held in reset
    if (!s_next.port_enable) begin
      s_next.hold_full = 1'h0;
      s_next.tx_busy = 1'h0;
      s_next.tx_cnt = 4'h0;
      s_next.rx_cnt = 4'h0;
      s_next.fcnt = 2'h0;
      s_next.overrun_flag = 1'h0;
      s_next.dt_out = 1'h0;
    end
    receive_complete_flag = s_reg.fcnt != 2'h0;
    transmit_buffer_empty_flag = !s_reg.hold_full;
    s_next.ck_oe = master;
    s_next.dt_oe = s_reg.sync && s_reg.port_enable && !(s_reg.single_receive_enable || s_reg.continuous_receive_enable);
    // receive request gated by its enable
    s_next.rxirq = receive_complete_flag && s_reg.receive_irq_enable;
    s_next.wake = (receive_complete_flag && s_reg.receive_irq_enable) || (transmit_buffer_empty_flag && s_reg.transmit_irq_enable && s_reg.peripheral_irq_enable);
    s_next.vect = s_next.wake && s_reg.global_irq_enable;
    s_next.rdata = ssps_pkg::RST_REG;
    if (rd_stb) begin
      unique case (addr)
        ssps_pkg::ADDR_TXSC: s_next.rdata = {s_reg.clock_source_master, s_reg.tx9, s_reg.transmit_enable, s_reg.sync, 1'h0,
                                             s_reg.high_speed_baud, !s_reg.tx_busy, s_reg.tx_ninth_bit};
        ssps_pkg::ADDR_RXSC: s_next.rdata = {s_reg.port_enable, s_reg.rx9, s_reg.single_receive_enable, s_reg.continuous_receive_enable, 2'h0,
                                             s_reg.overrun_flag, s_reg.fifo[s_reg.fhead][8]};
        ssps_pkg::ADDR_BAUDC: s_next.rdata = {1'h0, !(rxm && s_reg.rx_cnt != 4'h0), 2'h0, s_reg.wide, 3'h0};
        ssps_pkg::ADDR_BRGL: s_next.rdata = s_reg.brg[7:0];
        ssps_pkg::ADDR_HIGH_SPEED_BAUD: s_next.rdata = s_reg.brg[15:8];
        ssps_pkg::ADDR_TXD: s_next.rdata = ssps_pkg::RST_REG;
        ssps_pkg::ADDR_RXD: s_next.rdata = s_reg.fifo[s_reg.fhead][7:0];
        ssps_pkg::ADDR_IRQC: s_next.rdata = {2'h0, transmit_buffer_empty_flag, receive_complete_flag, s_reg.global_irq_enable, s_reg.peripheral_irq_enable, s_reg.transmit_irq_enable, s_reg.receive_irq_enable};
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_slave_clk;
    (slave) |=> !clock_pin_oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("clock driver on in slave mode");

  property p_slave_tx_dir;
    (slave && !s_reg.single_receive_enable && !s_reg.continuous_receive_enable) |=> data_pin_oe;
  endproperty
  a_slave_tx_dir: assert property (p_slave_tx_dir) else $error("slave transmitter not driving data");

  property p_port_reset;
    (wr_rxsc && !wdata[ssps_pkg::RX_PORT_ENABLE]) |=> (s_reg.fcnt == 2'h0) && !s_reg.overrun_flag && !s_reg.tx_busy;
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("disable did not reset port");

  property p_tx_reload;
    (txm && tx_done && s_reg.hold_full && !wr_stb) |=> s_reg.tx_busy && !s_reg.hold_full;
  endproperty
  a_tx_reload: assert property (p_tx_reload) else $error("second character not loaded");

  property p_tx_lead;
    (txm && s_reg.tx_busy && lead) |=> (data_pin_out == $past(s_reg.transmit_shift_register[0]));
  endproperty
  a_tx_lead: assert property (p_tx_lead) else $error("data did not change on leading edge");

  sequence s_last_slot;
    rx_done && (s_reg.fcnt == 2'h2) && !pop && !wr_stb;
  endsequence
  property p_overrun;
    s_last_slot |=> s_reg.overrun_flag && (s_reg.fcnt == 2'h2) ##1 !rx_done;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged or not blocking");

  property p_overrun_flag_clear;
    (s_reg.overrun_flag && wr_rxsc && !wdata[ssps_pkg::RX_CONTINUOUS_RECEIVE_ENABLE] && !rx_done) |=> !s_reg.overrun_flag;
  endproperty
  a_overrun_flag_clear: assert property (p_overrun_flag_clear) else $error("overrun not cleared");

  property p_single_receive_enable_clear;
    (master && rx_done && !wr_rxsc) |=> !s_reg.single_receive_enable;
  endproperty
  a_single_receive_enable_clear: assert property (p_single_receive_enable_clear) else $error("single receive not cleared");

  sequence s_first_char;
    rx_done && (s_reg.fcnt == 2'h0) && s_reg.receive_irq_enable && !wr_stb;
  endsequence
  property p_rx_req;
    s_first_char |=> receive_complete_flag ##1 (rx_irq_req && wake_req);
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("receive request missing");

  property p_tx_wake;
    (transmit_buffer_empty_flag && s_reg.transmit_irq_enable && s_reg.peripheral_irq_enable) |=> wake_req && (vector_req == $past(s_reg.global_irq_enable));
  endproperty
  a_tx_wake: assert property (p_tx_wake) else $error("transmit wake wrong");

  property p_slave_rx;
    (slave && s_reg.single_receive_enable && !s_reg.continuous_receive_enable && !s_reg.overrun_flag && trail && s_reg.rx_cnt == 4'h0) |=> (s_reg.rx_cnt == 4'h1);
  endproperty
  a_slave_rx: assert property (p_slave_rx) else $error("slave receiver idle");
endmodule : ssps_top

// >>> ssps_master.sv
// external synchronous clock master model facing the serial port pins
`timescale 1ns/1ps
module ssps_master (
  input wire logic clk_i,
  output logic clk_o,
  output logic dat_o,
  input wire logic dat_i
);
  initial begin
    clk_o = 1'b0;
    dat_o = 1'b1;
  end
  // one 8-bit frame, lsb first; clock idles low and stands still between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #137;
    for (int i = 0; i < 8; i++) begin
      dat_o = tx[i];
      clk_o = 1'b1;
      #400;
      clk_o = 1'b0;
      #50 rx[i] = dat_i;
      #350;
    end
    // a released line must not keep showing the last bit
    dat_o = ~tx[7];
  endtask : xfer
  // answers a clock that the port drives itself: one 8-bit frame, lsb first
  task automatic serve(input logic [7:0] tx);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      dat_o = tx[i];
    end
    // last bit is taken at the trailing edge, then the line shows its inverse
    @(negedge clk_i);
    dat_o = ~tx[7];
  endtask : serve
endmodule : ssps_master

// >>> sync_serial_port_slave_mode_bench.sv
// self-checking bench for the synchronous serial port in slave mode, plus one master single receive
`timescale 1ns/1ps
`define SSPS_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sync_serial_port_slave_mode_bench;
  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
    logic [7:0] exp;
  } ssps_row_s;
  logic mclk;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic cko, ckoe, dto, dtoe, irq, wake, vec, m_clk, m_dat;
  logic [7:0] rd_val, got;
  int bad_count = 0;
  int checks_done = 0;
  int cyc_count = 0;
  int ck_rises = 0;
  int ck_base = 0;
  wire ck_wire = ckoe ? cko : m_clk;
  wire dt_wire = dtoe ? dto : m_dat;
  ssps_row_s rows [9] = '{
    '{1'b0, ssps_pkg::ADDR_TXSC, 8'h00, 8'hFD, 8'h00},
    '{1'b0, ssps_pkg::ADDR_RXSC, 8'h00, 8'hFF, 8'h00},
    '{1'b0, ssps_pkg::ADDR_IRQC, 8'h00, 8'h0F, 8'h00},
    '{1'b1, ssps_pkg::ADDR_BRGL, 8'hA5, 8'hFF, 8'hA5},
    '{1'b1, ssps_pkg::ADDR_HIGH_SPEED_BAUD, 8'h3C, 8'hFF, 8'h3C},
    '{1'b1, ssps_pkg::ADDR_BAUDC, 8'h08, 8'h08, 8'h08},
    '{1'b1, ssps_pkg::ADDR_IRQC, 8'h0F, 8'h0F, 8'h0F},
    '{1'b0, ssps_pkg::ADDR_TXD, 8'h00, 8'hFF, 8'h00},
    '{1'b1, ssps_pkg::ADDR_IRQC, 8'h00, 8'h0F, 8'h00}};
  ssps_top i_ssps_top (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .clock_pin_in(ck_wire), .clock_pin_out(cko), .clock_pin_oe(ckoe),
    .data_pin_in(dt_wire), .data_pin_out(dto), .data_pin_oe(dtoe),
    .rx_irq_req(irq), .wake_req(wake), .vector_req(vec));
  ssps_master i_ssps_master (.clk_i(ck_wire), .clk_o(m_clk), .dat_o(m_dat), .dat_i(dt_wire));
  // counts rises on the clock line, whoever drives it
  always @(posedge ck_wire) ck_rises++;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : gap
  task automatic complete_run;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // cuts a hang short
  always @(posedge mclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    #1;
    `SSPS_CHK({rdata, ckoe, dtoe, irq, wake, vec}, 13'h0000)
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      rd(rows[i].addr, rd_val);
      `SSPS_CHK(rd_val & rows[i].mask, rows[i].exp)
    end
    // slave transmit with two characters queued
    wr(ssps_pkg::ADDR_RXSC, 8'h80);
    wr(ssps_pkg::ADDR_TXSC, 8'h30);
    wr(ssps_pkg::ADDR_IRQC, 8'h0E);
    wr(ssps_pkg::ADDR_TXD, 8'hA5);
    gap(3);
    wr(ssps_pkg::ADDR_TXD, 8'h3C);
    rd(ssps_pkg::ADDR_IRQC, rd_val);
    `SSPS_CHK(rd_val[5], 1'b0)
    `SSPS_CHK({ckoe, dtoe, wake}, 3'b010)
    i_ssps_master.xfer(8'h00, got);
    `SSPS_CHK(got, 8'hA5)
    gap(4);
    rd(ssps_pkg::ADDR_IRQC, rd_val);
    `SSPS_CHK(rd_val[5], 1'b1)
    `SSPS_CHK({wake, vec}, 2'b11)
    wr(ssps_pkg::ADDR_IRQC, 8'h06);
    gap(2);
    `SSPS_CHK({wake, vec}, 2'b10)
    wr(ssps_pkg::ADDR_IRQC, 8'h02);
    gap(2);
    `SSPS_CHK(wake, 1'b0)
    i_ssps_master.xfer(8'h00, got);
    `SSPS_CHK(got, 8'h3C)
    // slave receive with only the single-receive enable set
    gap(4);
    wr(ssps_pkg::ADDR_TXSC, 8'h10);
    wr(ssps_pkg::ADDR_IRQC, 8'h09);
    wr(ssps_pkg::ADDR_RXSC, 8'hA0);
    gap(2);
    `SSPS_CHK({ckoe, dtoe}, 2'b00)
    i_ssps_master.xfer(8'h5A, got);
    gap(4);
    `SSPS_CHK({irq, wake, vec}, 3'b111)
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    rd(ssps_pkg::ADDR_RXD, rd_val);
    `SSPS_CHK(rd_val, 8'h5A)
    // three characters overrun the two-deep receiver
    wr(ssps_pkg::ADDR_IRQC, 8'h00);
    wr(ssps_pkg::ADDR_RXSC, 8'h90);
    for (int k = 1; k < 4; k++) i_ssps_master.xfer({k[3:0], k[3:0]}, got);
    gap(4);
    `SSPS_CHK(irq, 1'b0)
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    `SSPS_CHK(rd_val[1], 1'b1)
    for (int k = 1; k < 3; k++) begin
      rd(ssps_pkg::ADDR_RXD, rd_val);
      `SSPS_CHK(rd_val, {k[3:0], k[3:0]})
    end
    i_ssps_master.xfer(8'h44, got);
    gap(4);
    rd(ssps_pkg::ADDR_IRQC, rd_val);
    `SSPS_CHK(rd_val[4], 1'b0)
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    `SSPS_CHK(rd_val[1], 1'b1)
    wr(ssps_pkg::ADDR_RXSC, 8'h80);
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    `SSPS_CHK(rd_val[1], 1'b0)
    // overrun again, cleared by turning the port off
    wr(ssps_pkg::ADDR_RXSC, 8'h90);
    repeat (3) i_ssps_master.xfer(8'h55, got);
    gap(4);
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    `SSPS_CHK(rd_val[1], 1'b1)
    wr(ssps_pkg::ADDR_RXSC, 8'h10);
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    `SSPS_CHK(rd_val[1], 1'b0)
    rd(ssps_pkg::ADDR_IRQC, rd_val);
    `SSPS_CHK(rd_val[4], 1'b0)
    // master single receive: the port makes the clock for one character only
    wr(ssps_pkg::ADDR_BAUDC, 8'h00);
    wr(ssps_pkg::ADDR_BRGL, 8'h03);
    wr(ssps_pkg::ADDR_TXSC, 8'h90);
    wr(ssps_pkg::ADDR_RXSC, 8'h80);
    ck_base = ck_rises;
    wr(ssps_pkg::ADDR_RXSC, 8'hA0);
    i_ssps_master.serve(8'hC3);
    gap(12);
    `SSPS_CHK(ck_rises - ck_base, 8)
    `SSPS_CHK(ckoe, 1'b1)
    rd(ssps_pkg::ADDR_IRQC, rd_val);
    `SSPS_CHK(rd_val[4], 1'b1)
    rd(ssps_pkg::ADDR_RXSC, rd_val);
    `SSPS_CHK(rd_val[5], 1'b0)
    rd(ssps_pkg::ADDR_RXD, rd_val);
    `SSPS_CHK(rd_val, 8'hC3)
    // reset in mid-run returns the pin enables, requests, read data and low baud byte to zero
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    #1;
    `SSPS_CHK({rdata, ckoe, dtoe, irq, wake, vec}, 13'h0000)
    rd(ssps_pkg::ADDR_BRGL, rd_val);
    `SSPS_CHK(rd_val, 8'h00)
    complete_run();
  end
endmodule : sync_serial_port_slave_mode_bench
